// >>> rtl/adc_serial_config_readout.v
// Serial configuration capture, sequencer and result readout of the converter
`timescale 1ns/1ps
`include "adc_serial_defs.vh"
module adc_serial_config_readout (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // Serial pins
  input wire i_conversion_start_pin,
  input wire i_sck,
  input wire i_din,
  output reg o_serial_result_out,
  output reg o_serial_result_out_oe_n,
  // Conversion core results
  input wire i_core_valid,
  input wire [`RESULT_WIDTH-1:0] i_core_data,
  output wire o_core_ready,
  // Converter state
  output reg o_converting,
  output reg o_end_of_conversion,
  output reg [`CFG_WIDTH-1:0] o_converter_configuration,
  output reg [2:0] o_channel,
  output reg o_temp_select
);
  // Pin synchronisers and edge history
  reg start_meta, start_sync, start_prev;
  reg sck_meta, sck_sync, sck_prev;
  reg din_meta, din_sync;
  wire start_rise;
  wire start_fall;
  wire sck_rise;
  wire sck_fall;
  // Conversion timing
  reg [`CONV_CNT_WIDTH-1:0] conv_cnt;
  wire eoc;
  // Configuration capture
  reg [`CFG_WIDTH-1:0] cfg_shift;
  reg [3:0] cfg_cnt;
  reg [`CFG_WIDTH-1:0] cfg_conv;
  // Readout
  reg [`FRAME_WIDTH-1:0] out_shift;
  reg [4:0] fall_cnt;
  reg [4:0] frame_bits;
  reg busy_mode;
  reg rd_active;
  reg data_pending;
  wire [4:0] fall_limit;
  wire [`RESULT_WIDTH-1:0] buf_data;
  wire buf_valid;
  wire [1:0] scan_mode;
  wire [2:0] last_channel;

  // Pins from outside pass two flip-flops first
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      // Start pin idles high: no false edge after reset
      start_meta <= 1'b1;
      start_sync <= 1'b1;
      start_prev <= 1'b1;
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end
    else
    begin
      start_meta <= i_conversion_start_pin;
      start_sync <= start_meta;
      start_prev <= start_sync;
      sck_meta <= i_sck;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      din_meta <= i_din;
      din_sync <= din_meta;
    end
  end

  // Edges seen on the synchronised pins
  assign start_rise = start_sync && !start_prev;
  assign start_fall = !start_sync && start_prev;
  assign sck_rise = sck_sync && !sck_prev;
  assign sck_fall = !sck_sync && sck_prev;
  assign eoc = o_converting && (conv_cnt == {`CONV_CNT_WIDTH{1'b0}});
  assign scan_mode = o_converter_configuration[`CFG_SCAN_HI:`CFG_SCAN_LO];
  assign last_channel = o_converter_configuration[`CFG_LAST_HI:`CFG_LAST_LO];
  // One extra falling edge returns the pin to hi-z in busy mode
  assign fall_limit = frame_bits + {4'h0, busy_mode};

  // Result hand-off from the core, drained at each end of conversion
  result_buffer2 #(
    .WIDTH(`RESULT_WIDTH)
  ) u_result_buffer (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_in_valid(i_core_valid),
    .i_in_data(i_core_data),
    .o_in_ready(o_core_ready),
    .o_out_valid(buf_valid),
    .o_out_data(buf_data),
    .i_out_ready(eoc)
  );

  // Conversion timer and scan position
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_converting <= 1'b0;
      o_end_of_conversion <= 1'b0;
      conv_cnt <= {`CONV_CNT_WIDTH{1'b0}};
      o_channel <= 3'h0;
      o_temp_select <= 1'b0;
      cfg_conv <= `CFG_RESET;
    end
    else
    begin
      o_end_of_conversion <= eoc;
      if (start_rise && !o_converting)
      begin
        o_converting <= 1'b1;
        conv_cnt <= `CONV_LOAD;
        cfg_conv <= o_converter_configuration;
        if (scan_mode == `SCAN_OFF)
        begin
          o_channel <= last_channel;
          o_temp_select <= 1'b0;
        end
        else if (o_temp_select || o_channel == last_channel)
        begin
          // Wrap to channel zero, optionally via the temperature sensor
          o_temp_select <= !o_temp_select && (scan_mode == `SCAN_WITH_TEMP);
          o_channel <= 3'h0;
        end
        else
          o_channel <= o_channel + 3'h1;
      end
      else if (eoc)
        o_converting <= 1'b0;
      else if (o_converting)
        conv_cnt <= conv_cnt - 1'b1;
    end
  end

  // Configuration capture on rising clock edges while the start pin is low
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      cfg_shift <= {`CFG_WIDTH{1'b0}};
      cfg_cnt <= 4'h0;
      o_converter_configuration <= `CFG_RESET;
    end
    else
    begin
      if (eoc)
      begin
        // Only a whole word takes effect, at the end of conversion
        if (cfg_cnt == `CFG_COUNT)
          o_converter_configuration <= cfg_shift;
        cfg_cnt <= 4'h0;
      end
      else if (sck_rise && !start_sync && cfg_cnt != `CFG_COUNT)
      begin
        cfg_shift <= {cfg_shift[`CFG_WIDTH-2:0], din_sync};
        cfg_cnt <= cfg_cnt + 4'h1;
      end
    end
  end

  // Serial result output
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_serial_result_out <= 1'b0;
      o_serial_result_out_oe_n <= 1'b1;
      out_shift <= {`FRAME_WIDTH{1'b0}};
      fall_cnt <= 5'h0;
      frame_bits <= `BITS_NO_READBACK;
      busy_mode <= 1'b0;
      rd_active <= 1'b0;
      data_pending <= 1'b0;
    end
    else if (start_rise)
    begin
      // Start of conversion releases the pin and stops any read
      o_serial_result_out_oe_n <= 1'b1;
      rd_active <= 1'b0;
      data_pending <= 1'b0;
    end
    else if (eoc)
    begin
      // New result replaces whatever was not read
      out_shift <= {buf_valid ? buf_data : {`RESULT_WIDTH{1'b0}}, cfg_conv};
      frame_bits <= cfg_conv[`CFG_RBN_BIT] ? `BITS_NO_READBACK : `BITS_READBACK;
      fall_cnt <= 5'h0;
      busy_mode <= !start_sync;
      if (!start_sync)
      begin
        // Ready shown by driving low; a held low bit gives no edge
        o_serial_result_out <= 1'b0;
        o_serial_result_out_oe_n <= 1'b0;
        rd_active <= 1'b1;
        data_pending <= 1'b0;
      end
      else
      begin
        o_serial_result_out_oe_n <= 1'b1;
        rd_active <= 1'b0;
        data_pending <= 1'b1;
      end
    end
    else if (start_fall && data_pending)
    begin
      // Start pin low after the end: MSB onto the pin
      o_serial_result_out <= out_shift[`FRAME_WIDTH-1];
      out_shift <= {out_shift[`FRAME_WIDTH-2:0], 1'b0};
      o_serial_result_out_oe_n <= 1'b0;
      rd_active <= 1'b1;
      data_pending <= 1'b0;
    end
    else if (sck_fall && rd_active && !start_sync)
    begin
      fall_cnt <= fall_cnt + 5'h1;
      if (fall_cnt + 5'h1 >= fall_limit)
      begin
        o_serial_result_out_oe_n <= 1'b1;
        rd_active <= 1'b0;
      end
      else
      begin
        o_serial_result_out <= out_shift[`FRAME_WIDTH-1];
        out_shift <= {out_shift[`FRAME_WIDTH-2:0], 1'b0};
      end
    end
  end
endmodule // adc_serial_config_readout

// >>> rtl/adc_serial_defs.vh
// Constants for the converter serial configuration and readout block
`ifndef ADC_SERIAL_DEFS_VH
`define ADC_SERIAL_DEFS_VH
`define CFG_WIDTH 14
`define CFG_RESET 14'h3fff
`define CFG_SCAN_HI 2
`define CFG_SCAN_LO 1
`define CFG_COUNT 4'he
`define CFG_RBN_BIT 0
`define CFG_LAST_HI 9
`define CFG_LAST_LO 7
`define SCAN_OFF 2'h0
`define SCAN_WITH_TEMP 2'h2
`define RESULT_WIDTH 16
`define FRAME_WIDTH 30
`define BITS_NO_READBACK 5'h10
`define BITS_READBACK 5'h1e
`define CLK_PERIOD_NS 4
`define T_CONV_NS 2200
`define CONV_CYCLES (`T_CONV_NS / `CLK_PERIOD_NS)
`define CONV_CNT_WIDTH 10
`define CONV_LOAD 10'h225
`endif

// >>> rtl/result_buffer2.v
// Two-entry buffer between the conversion core and the serial readout
`timescale 1ns/1ps
module result_buffer2 #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // Filling side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_in_ready,
  // Draining side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  reg [WIDTH-1:0] entry0;
  reg [WIDTH-1:0] entry1;
  reg [1:0] count;
  reg [1:0] next_count;
  wire push;
  wire pop;

  // Handshakes on both sides
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_valid = (count != 2'h0);
  assign o_out_data = entry0;

  // Occupancy after this cycle
  always @*
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 2'h1;
    else if (pop && !push)
      next_count = count - 2'h1;
  end

  // Storage: entry0 is the head
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      entry0 <= {WIDTH{1'b0}};
      entry1 <= {WIDTH{1'b0}};
      count <= 2'h0;
      o_in_ready <= 1'b0;
    end
    else
    begin
      count <= next_count;
      o_in_ready <= (next_count != 2'h2);
      if (pop)
      begin
        entry0 <= (count == 2'h2) ? entry1 : i_in_data;
        if (push && count == 2'h2)
          entry1 <= i_in_data;
      end
      else if (push)
      begin
        if (count == 2'h0)
          entry0 <= i_in_data;
        else
          entry1 <= i_in_data;
      end
    end
  end
endmodule // result_buffer2

// >>> verification/adc_serial_properties.sv
// Port checker for the converter serial configuration and readout block
`timescale 1ns/1ps
`include "adc_serial_defs.vh"
module adc_serial_properties (
  // Clock, reset and pins
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_conversion_start_pin,
  input wire i_sck,
  // Observed outputs
  input wire o_serial_result_out,
  input wire o_serial_result_out_oe_n,
  input wire o_converting,
  input wire o_end_of_conversion,
  input wire [`CFG_WIDTH-1:0] o_converter_configuration
);
  // One clock domain for every check
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  AST_EOC_ONE_CYCLE: assert property (o_end_of_conversion |=> !o_end_of_conversion)
    else $error("end of conversion pulse too long");
  AST_EOC_AFTER_CONV: assert property ($fell(o_converting) |-> o_end_of_conversion)
    else $error("no end of conversion after converting");
  AST_START_HIZ: assert property ($rose(i_conversion_start_pin) |-> ##[1:5] o_serial_result_out_oe_n)
    else $error("start edge left output driven");
  AST_BUSY_LOW: assert property (o_end_of_conversion && !i_conversion_start_pin
    && !$past(i_conversion_start_pin, 4) |-> ##1 !o_serial_result_out_oe_n && !o_serial_result_out)
    else $error("busy indicator missing");
  AST_NO_BUSY_HIZ: assert property (o_end_of_conversion && i_conversion_start_pin
    && $past(i_conversion_start_pin, 4) |-> ##1 o_serial_result_out_oe_n)
    else $error("busy indicator not disabled");
  AST_CFG_AT_EOC: assert property ($changed(o_converter_configuration) |-> ##[0:1] o_end_of_conversion)
    else $error("configuration changed away from end of conversion");
  AST_SHIFT_ON_FALL: assert property ($changed(o_serial_result_out) && !o_serial_result_out_oe_n
    && !$past(o_serial_result_out_oe_n) && !o_end_of_conversion && !$past(o_end_of_conversion)
    |-> !$past(i_sck, 2))
    else $error("output bit changed without clock fall");
  AST_RESET_IDLE: assert property (disable iff (1'b0) i_reset
    |=> o_serial_result_out_oe_n && !o_converting && !o_end_of_conversion)
    else $error("reset state wrong");

  // Main scenarios reached
  cover property (o_end_of_conversion && !o_serial_result_out_oe_n);
  cover property ($changed(o_converter_configuration));
  cover property ($fell(o_serial_result_out_oe_n));
endmodule // adc_serial_properties

bind adc_serial_config_readout adc_serial_properties props (.i_clk_sys, .i_reset,
  .i_conversion_start_pin, .i_sck, .o_serial_result_out, .o_serial_result_out_oe_n,
  .o_converting, .o_end_of_conversion, .o_converter_configuration);

// >>> verification/host_model.sv
// Host serial controller model driving clock, data and start pins
`timescale 1ns/1ps
module host_model (
  // Line from the converter, pulled up
  input wire i_line,
  // Pins to the converter
  output logic o_sck,
  output logic o_din,
  output logic o_start_pin
);
  logic busy = 0;
  logic [30:0] got;
  initial o_sck = 0;
  initial o_din = 0;
  initial o_start_pin = 1;

  // Start a conversion; in busy mode drop low before the end
  task automatic start();
    o_start_pin = 0;
    #16;
    o_start_pin = 1;
    o_sck = busy;
    #40;
    if (busy)
      o_start_pin = 0;
  endtask

  // Clock n bits: write config on rises, capture line before each rise
  task automatic frame(input logic [13:0] c, input int n);
    o_start_pin = 0;
    #24;
    for (int i = 0; i < n; i++)
    begin
      if (busy)
        o_sck = 0;
      o_din = (i < 14) ? c[13-i] : 1'h0;
      #16;
      got = {got[29:0], i_line};
      o_sck = 1;
      #16;
      if (!busy)
        o_sck = 0;
    end
    o_din = ~o_din;
  endtask
endmodule // host_model

// >>> verification/tb_top.sv
// Self-checking bench for the converter serial block
`timescale 1ns/1ps
`include "adc_serial_defs.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
  logic i_clk_sys = 0;
  logic i_reset = 1;
  logic i_core_valid = 0;
  logic [15:0] i_core_data = 0;
  wire i_conversion_start_pin, i_sck, i_din, o_serial_result_out, o_serial_result_out_oe_n;
  wire o_core_ready, o_converting, o_end_of_conversion, o_temp_select;
  wire [13:0] o_converter_configuration;
  wire [2:0] o_channel;
  int err_count = 0;
  int samples_checked = 0;
  logic [15:0] res [0:5] = '{16'ha5c3, 16'h5a3c, 16'hf00f, 16'h8001, 16'h7ffe, 16'h0ff0};

  // System clock
  always #2 i_clk_sys = ~i_clk_sys;

  host_model host (.i_line(o_serial_result_out_oe_n ? 1'h1 : o_serial_result_out),
    .o_sck(i_sck), .o_din(i_din), .o_start_pin(i_conversion_start_pin));
  adc_serial_config_readout DUT (.i_clk_sys, .i_reset, .i_conversion_start_pin, .i_sck,
    .i_din, .o_serial_result_out, .o_serial_result_out_oe_n, .i_core_valid, .i_core_data,
    .o_core_ready, .o_converting, .o_end_of_conversion, .o_converter_configuration,
    .o_channel, .o_temp_select);

  // Closing report
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hand one result to the core buffer
  task automatic push(input logic [15:0] d);
    int k;
    for (k = 0; k < 99 && o_core_ready !== 1'h1; k++)
      @(negedge i_clk_sys);
    if (k == 99)
    begin
      err_count++;
      report_and_stop();
    end
    i_core_valid = 1;
    i_core_data = d;
    @(negedge i_clk_sys);
    i_core_valid = 0;
  endtask

  // Wait for the end of conversion pulse
  task automatic wait_eoc();
    int k;
    for (k = 0; k < 800 && o_end_of_conversion !== 1'h1; k++)
      @(negedge i_clk_sys);
    if (k == 800)
      err_count++;
    if (k == 800)
      report_and_stop();
    repeat (2) @(negedge i_clk_sys);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge i_clk_sys);
    i_reset = 0;
    `CHK("cfg_reset", `CFG_RESET, o_converter_configuration)
    `CHK("oe_reset", 1'h1, o_serial_result_out_oe_n)
    push(res[0]);
    push(res[1]);
    `CHK("buffer_full", 1'h0, o_core_ready)
    $display("reset test done");
    host.start();
    wait_eoc();
    `CHK("no_busy_hiz", 1'h1, o_serial_result_out_oe_n)
    host.frame(14'h2180, 16);
    `CHK("result_a", res[0], host.got[15:0])
    host.start();
    wait_eoc();
    push(res[2]);
    `CHK("cfg_applied", 14'h2180, o_converter_configuration)
    host.frame(14'h2180, 16);
    `CHK("result_b", res[1], host.got[15:0])
    host.start();
    `CHK("channel", 3'h3, o_channel)
    `CHK("temp", 1'h0, o_temp_select)
    wait_eoc();
    push(res[3]);
    host.frame(14'h21b6, 10);
    `CHK("partial", res[2][15:6], host.got[9:0])
    host.start();
    wait_eoc();
    push(res[4]);
    `CHK("cfg_kept", 14'h2180, o_converter_configuration)
    host.frame(14'h2180, 30);
    `CHK("frame_rb", {res[3], 14'h2180}, host.got[29:0])
    $display("no busy test done");
    host.busy = 1;
    host.start();
    wait_eoc();
    push(res[5]);
    `CHK("busy_low", 2'h0, {o_serial_result_out_oe_n, o_serial_result_out})
    host.frame(14'h0185, 31);
    `CHK("busy_frame", {res[4], 14'h2180, 1'h1}, host.got)
    host.start();
    wait_eoc();
    push(res[0]);
    `CHK("cfg_busy", 14'h0185, o_converter_configuration)
    host.frame(14'h0185, 17);
    `CHK("busy_short", {res[5], 1'h1}, host.got[16:0])
    $display("busy test done");
    host.start();
    `CHK("scan_channel", 3'h0, o_channel)
    `CHK("scan_temp", 1'h1, o_temp_select)
    wait_eoc();
    host.frame(14'h0185, 17);
    `CHK("rb_off", {res[0], 1'h1}, host.got[16:0])
    $display("scan test done");
    report_and_stop();
  end
endmodule // tb_top
